// ---- inc/mrba_defs.svh ----
// Purpose: Constants for the management register bit access block.
// Assumes: 32 register slots of 16 bits, addressed by a 5-bit index.
// Notes: Access masks describe the bit type of every bit of every slot.
`ifndef MRBA_DEFS_SVH
`define MRBA_DEFS_SVH

`define MRBA_NUM_REGS 32
`define MRBA_OVR_REG 5'h10
`define MRBA_OVR_BIT 15
`define MRBA_STRAP_REG 5'h10
`define MRBA_STRAP_LSB 6
`define MRBA_REG_ZERO 5'h00
`define MRBA_ISO_BIT 10
`define MRBA_SYNC_STAGES 3

`endif

// ---- inc/mrba_pkg.sv ----
// Purpose: Types for the management register bit access block.
// Assumes: Nothing beyond the defines header.
// Notes: Access types are held as per-bit mask vectors in the core.
package mrba_pkg;
  typedef logic [15:0] mrba_word_t;
  typedef logic [4:0] mrba_addr_t;
  typedef enum logic [1:0] {
    mrba_acc_ro,
    mrba_acc_gated,
    mrba_acc_rw,
    mrba_acc_zero
  } mrba_acc_t;
  typedef enum {
    mrba_st_reset,
    mrba_st_run
  } mrba_state_t;
endpackage : mrba_pkg

// ---- core/mrba_core.sv ----
// Purpose: Bit-access policy and reset defaults of the 16-bit management
//   register set, fed by an already decoded management frame port.
// Assumes: Frame decoding is done elsewhere; wr_stb and rd_stb are one-cycle
//   pulses on clock; strap pins are asynchronous to clock.
// Notes: Masks per register select the access type of every bit.
//   Writes in the default-loading state are lost; wait for the straps.
// Operation
// - Read-only bits read back their value and ignore every write.
// - Gated bits always read, and writes are dropped while override is 0.
// - With override set, the next register write may change gated bits.
// - The override bit clears itself when that next register write ends.
// - Read/write bits are read at any time and written whenever defaults are not being loaded.
// - Write-zero-only bits read freely and only accept a zero being written.
// - Every bit with a default takes that default after any reset.
// - Strap-dependent defaults come from the strap pins sampled at reset.
// - Reads of missing registers give zero and writes to them are dropped.
`timescale 1ns/1ns
`include "mrba_defs.svh"
module mrba_core
  import mrba_pkg::*;
#(
  parameter int num_regs = `MRBA_NUM_REGS,
  parameter logic [num_regs-1:0] present = num_regs'(32'h000f_01ff),
  parameter logic [num_regs*16-1:0] ro_mask = '0,
  parameter logic [num_regs*16-1:0] gated_mask = '0,
  parameter logic [num_regs*16-1:0] zero_mask = '0,
  parameter logic [num_regs*16-1:0] defaults = '0,
  parameter logic [num_regs*16-1:0] has_default = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic addr0_led_strap,
  input wire logic addr1_led_strap,
  input wire logic addr2_led_strap,
  input wire logic addr3_led_strap,
  input wire logic addr4_led_strap,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wr_data,
  input wire logic [num_regs*16-1:0] hw_value,
  input wire logic [num_regs*16-1:0] hw_load,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic override_gated_write,
  output logic [4:0] phy_addr,
  output logic [num_regs*16-1:0] reg_flat
);
  logic [15:0] regs [num_regs];
  logic [`MRBA_SYNC_STAGES-1:0] strap_sync [5];
  logic [$clog2(`MRBA_SYNC_STAGES+1)-1:0] fill;
  logic [$clog2(`MRBA_SYNC_STAGES+1)-1:0] next_fill;
  logic [4:0] strap_pins;
  logic [4:0] strap_stable;
  logic [4:0] next_strap;
  mrba_state_t state;
  mrba_state_t next_state;
  logic sync_filled;
  logic straps_settled;
  logic load_defaults;
  logic addr_ok;
  logic ovr_write;
  logic ovr_consume;
  logic [15:0] rd_word;

  assign strap_pins = {addr4_led_strap, addr3_led_strap, addr2_led_strap,
                       addr1_led_strap, addr0_led_strap};
  assign addr_ok = (32'(reg_addr) < num_regs) && present[reg_addr];
  // Override bit sits in a gated-free slot; write to it is plain R/W
  assign ovr_write = wr_stb && addr_ok && (reg_addr == `MRBA_OVR_REG);
  // Any other write, even to a missing slot, uses up the override
  assign ovr_consume = wr_stb && override_gated_write && !ovr_write;
  assign override_gated_write = regs[`MRBA_OVR_REG][`MRBA_OVR_BIT];
  assign load_defaults = (state == mrba_st_reset) || soft_rst;

  // Three stages: the first may go metastable, the last two vote
  // Straps are only trusted once two late stages agree
  genvar s;
  generate
    for (s = 0; s < 5; s++) begin : g_strap
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          strap_sync[s] <= '0;
        end else begin
          strap_sync[s] <= {strap_sync[s][`MRBA_SYNC_STAGES-2:0],
                            strap_pins[s]};
        end
      end
      assign strap_stable[s] = strap_sync[s][2] == strap_sync[s][1];
      assign next_strap[s] = strap_stable[s] ? strap_sync[s][2]
                                             : phy_addr[s];
    end
  endgenerate

  // The stages leave reset holding zeros that already agree, so the
  // straps count only once the pins have walked through every stage.
  assign sync_filled = 32'(fill) == `MRBA_SYNC_STAGES;
  assign next_fill = sync_filled ? fill : fill + 1'b1;
  assign straps_settled = sync_filled && (&strap_stable);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  // Stay in default loading until the straps have settled
  always_comb begin
    next_state = state;
    unique case (state)
      mrba_st_reset: begin
        if (straps_settled) begin
          next_state = mrba_st_run;
        end
      end
      mrba_st_run: begin
        next_state = mrba_st_run;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= mrba_st_reset;
    end else begin
      state <= next_state;
    end
  end

  // Latch straps on every default load, then hold them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phy_addr <= '0;
    end else if (load_defaults) begin
      phy_addr <= next_strap;
    end
  end

  // One slot per register; each bit follows its own mask
  genvar r;
  generate
    for (r = 0; r < num_regs; r++) begin : g_reg
      logic [15:0] ro_m;
      logic [15:0] gt_m;
      logic [15:0] zo_m;
      logic [15:0] dflt;
      logic [15:0] dflt_en;
      logic [15:0] gate_open;
      logic [15:0] wr_m;
      logic [15:0] zero_clr;
      logic [15:0] written;
      logic [15:0] next_val;
      logic [15:0] reload;
      logic [15:0] next_reg;
      logic [15:0] base;
      logic hit;
      logic self_clear;
      assign ro_m = ro_mask[r*16 +: 16];
      assign gt_m = gated_mask[r*16 +: 16];
      assign zo_m = zero_mask[r*16 +: 16];
      assign dflt_en = has_default[r*16 +: 16];
      // Strap bits and isolate follow the latched address
      assign dflt = (r == `MRBA_STRAP_REG)
        ? ((defaults[r*16 +: 16] & ~(16'h001f << `MRBA_STRAP_LSB))
           | (16'(next_strap) << `MRBA_STRAP_LSB))
        : (r == `MRBA_REG_ZERO)
        ? ((defaults[r*16 +: 16] & ~(16'h0001 << `MRBA_ISO_BIT))
           | (16'(next_strap == 5'h00) << `MRBA_ISO_BIT))
        : defaults[r*16 +: 16];
      assign hit = wr_stb && addr_ok && (reg_addr == 5'(r));
      // Gated bits open only while the override is set
      assign gate_open = override_gated_write ? 16'hffff : ~gt_m;
      assign wr_m = ~ro_m & ~zo_m & gate_open;
      // Zero-only bits may be cleared by a written zero, never set
      assign zero_clr = zo_m & ~wr_data;
      // Hardware updates land first; a write then wins on the bits it owns
      assign base = (regs[r] & ~hw_load[r*16 +: 16])
                    | (hw_value[r*16 +: 16] & hw_load[r*16 +: 16]);
      assign written = ((base & ~wr_m) | (wr_data & wr_m)) & ~zero_clr;
      assign next_val = hit ? written : base;
      // Bits without a default keep what they hold across a soft reset
      assign reload = (dflt & dflt_en) | (regs[r] & ~dflt_en);
      assign self_clear = (r == `MRBA_OVR_REG) && ovr_consume;
      // Reload beats a write; the override drops on the write that uses it
      assign next_reg = load_defaults ? reload
        : self_clear ? (next_val & ~(16'h0001 << `MRBA_OVR_BIT))
        : next_val;
      assign reg_flat[r*16 +: 16] = regs[r];
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          regs[r] <= '0;
        end else begin
          regs[r] <= next_reg;
        end
      end
    end
  endgenerate

  // Missing slots read as zero so a probe of the map never sees stale data
  assign rd_word = addr_ok ? regs[reg_addr] : 16'h0000;

  // Answer one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
    end
  end

  // Read data holds between reads so a slow poller can still pick it up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_stb) begin
      rd_data <= rd_word;
    end
  end
endmodule : mrba_core

// ---- verification/mrba_sta.sv ----
// Purpose: Station manager model issuing decoded reads and writes.
// Assumes: One request at a time, launched after a rising edge.
// Notes: Callers keep reserved bits at their defaults.
`timescale 1ns/1ns
module mrba_sta (
  input wire logic clock,
  output logic wr_stb,
  output logic rd_stb,
  output logic [4:0] reg_addr,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    reg_addr = 5'h00;
    wr_data = 16'h0000;
  end
  // Data is written exactly as given; callers keep reserved bits at their defaults
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    reg_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
    wr_data <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    rd_stb <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rd_valid ? rd_data : 16'hxxxx;
  endtask : rd
endmodule : mrba_sta

// ---- verification/mrba_chk_assertions.sv ----
// Purpose: Bit-access checks on the register core.
// Assumes: hw_load idle when a write is judged.
// Notes: Masks come from the bound instance.
`timescale 1ns/1ns
module mrba_chk #(
  parameter logic [31:0] present = '0,
  parameter logic [511:0] ro_mask = '0,
  parameter logic [511:0] gated_mask = '0,
  parameter logic [511:0] zero_mask = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wr_data,
  input wire logic [511:0] hw_load,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic override_gated_write,
  input wire logic [511:0] reg_flat
);
  wire [15:0] cur = reg_flat[reg_addr*16 +: 16];
  wire [15:0] rom = ro_mask[reg_addr*16 +: 16];
  wire [15:0] gm = gated_mask[reg_addr*16 +: 16];
  wire [15:0] zm = zero_mask[reg_addr*16 +: 16];
  wire [15:0] rw = ~(rom | gm | zm);
  wire go = wr_stb && !soft_rst && hw_load == '0 && present[reg_addr];
  wire use_ovr = go && override_gated_write && reg_addr != 5'h10;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (rd_stb |=> rd_valid)
    else $error("read not answered");
  absent_read_a: assert property (
    rd_stb && !present[reg_addr] |=> rd_data == 16'h0000) else $error("bad");
  ro_hold_a: assert property (
    go |=> (cur & rom) == $past(cur & rom)) else $error("ro moved");
  gated_lock_a: assert property (
    go && !override_gated_write |=> (cur & gm) == $past(cur & gm))
    else $error("gated moved");
  gated_open_a: assert property (
    use_ovr |=> (cur & gm) == $past(wr_data & gm)) else $error("gated held");
  ovr_clear_a: assert property (
    use_ovr |=> !override_gated_write) else $error("override kept");
  rw_write_a: assert property (
    go |=> (cur & rw) == $past(wr_data & rw)) else $error("rw wrong");
  zero_only_a: assert property (
    go |=> (cur & zm) == $past(cur & wr_data & zm)) else $error("zero bit");
endmodule : mrba_chk
bind mrba_core mrba_chk #(.present(present), .ro_mask(ro_mask),
  .gated_mask(gated_mask), .zero_mask(zero_mask)) chk (.clock(clock),
  .rst(rst), .soft_rst(soft_rst), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .reg_addr(reg_addr), .wr_data(wr_data), .hw_load(hw_load),
  .rd_data(rd_data), .rd_valid(rd_valid), .reg_flat(reg_flat),
  .override_gated_write(override_gated_write));

// ---- verification/mgmt_register_bit_access_tb.sv ----
// Purpose: Self-checking bench for the register bit access core.
// Assumes: Straps steady outside the strap scenario; hardware load idle.
// Notes: Reg 1 mixes all four bit types; reg 16 holds straps.
`timescale 1ns/1ns
module mgmt_register_bit_access_tb;
  localparam logic [511:0] ro = (512'h000f << 16) | (512'h07c0 << 256);
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic [4:0] strap = 5'h13;
  logic wr_stb, rd_stb, rd_valid, ovr;
  logic [4:0] reg_addr, phy_addr;
  logic [15:0] wr_data, rd_data, v;
  int err_count = 0;
  int n_compared = 0;
  mrba_core #(.ro_mask(ro), .gated_mask(512'h00f0 << 16),
    .zero_mask(512'h0f00 << 16), .defaults(512'h0a5a << 16)) DUT (
    .clock(clock), .rst(rst), .soft_rst(soft_rst),
    .addr0_led_strap(strap[0]), .addr1_led_strap(strap[1]),
    .addr2_led_strap(strap[2]), .addr3_led_strap(strap[3]),
    .addr4_led_strap(strap[4]), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .reg_addr(reg_addr), .wr_data(wr_data), .hw_value('0), .hw_load('0),
    .rd_data(rd_data), .rd_valid(rd_valid), .override_gated_write(ovr),
    .phy_addr(phy_addr), .reg_flat());
  mrba_sta sta (.clock(clock), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic t_access;
    sta.wr(5'h01, 16'hffff);
    sta.rd(5'h01, v);
    check(v, 16'hfa5a);
    sta.wr(5'h01, 16'h0000);
    sta.rd(5'h01, v);
    check(v, 16'h005a);
    sta.wr(5'h14, 16'hffff);
    sta.rd(5'h14, v);
    check(v, 16'h0000);
  endtask : t_access
  task automatic t_override;
    sta.wr(5'h10, {1'b1, 4'h0, strap, 6'h00});
    check({15'h0000, ovr}, 16'h0001);
    sta.wr(5'h01, 16'h00f0);
    check({15'h0000, ovr}, 16'h0000);
    sta.wr(5'h01, 16'h0000);
    sta.rd(5'h01, v);
    check(v, 16'h00fa);
  endtask : t_override
  task automatic t_defaults;
    sta.rd(5'h10, v);
    check(v, {5'h00, strap, 6'h00});
    check({11'h000, phy_addr}, {11'h000, strap});
    sta.rd(5'h00, v);
    check(v, 16'h0000);
    sta.rd(5'h01, v);
    check(v, 16'h0a5a);
  endtask : t_defaults
  task automatic t_strap_zero;
    @(posedge clock);
    strap <= 5'h00;
    repeat (4) @(posedge clock);
    check({11'h000, phy_addr}, 16'h0013);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    sta.rd(5'h00, v);
    check(v, 16'h0400);
    check({11'h000, phy_addr}, 16'h0000);
    @(posedge clock);
    strap <= 5'h13;
    repeat (4) @(posedge clock);
  endtask : t_strap_zero
  task automatic t_hard;
    sta.wr(5'h01, 16'hf000);
    sta.rd(5'h01, v);
    check(v, 16'hf05a);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_defaults;
  endtask : t_hard
  task automatic t_soft;
    @(posedge clock);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_defaults;
  endtask : t_soft
  initial forever #4 clock = ~clock;
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_defaults;
    t_access;
    t_override;
    t_strap_zero;
    t_soft;
    t_hard;
    complete_run;
  end
  initial begin
    #20000;
    err_count++;
    complete_run;
  end
endmodule : mgmt_register_bit_access_tb
